// [dv/tb_vectored_interrupt_controller.sv]
// self-checking bench of the vectored interrupt controller
`timescale 1ns/100ps
`default_nettype none
`include "vic_defines.vh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tb_vectored_interrupt_controller;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  wire logic [43:0] periph_irq;
  wire logic [3:0] ext_int_pins;
  wire logic [15:0] io_drive, io_out, io_oe;
  wire logic [15:0] io_in = (io_oe & io_out) | (~io_oe & io_drive); // resolved pin level
  wire logic normal_irq_request, fast_irq_request, irq;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  int error_cnt = 0;
  int samples_checked = 0;
  int s, k, j;
  logic [15:0] dv;
  logic [31:0] rd_q;
  logic [1:0] rsp;
  logic [11:0] rst_addr [6] = '{`VIC_EN_LO, `VIC_EN_HI, `VIC_ROUTE_LO, `VIC_POL_LO,
    `VIC_PMASK, `VIC_IMASK};
  // ==========
  // clock, partner and design
  initial
    forever #4 sys_clk = ~sys_clk;
  vic_src_model PM (.sys_clk(sys_clk), .periph_irq(periph_irq), .ext_int_pins(ext_int_pins),
    .io_drive(io_drive));
  vic_top DUT (.clk_en(1'b1), .expanded_io_pins_in(io_in), .expanded_io_pins_out(io_out),
    .expanded_io_pins_oe(io_oe), .*);
  // ==========
  // verdict
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // one write or read
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    for (n = 0; n < 100; n++)
    begin
      @(posedge sys_clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready))
        break;
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    rsp = w ? s_axi_bresp : s_axi_rresp;
    rd_q = s_axi_rdata;
    if (n == 100)
    begin
      error_cnt++;
      conclude();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    `CHK("bresp", `VIC_RESP_OKAY, rsp)
  endtask
  task automatic rd(input logic [11:0] a);
    bus(1'b0, a, 32'h0);
    `CHK("rresp", `VIC_RESP_OKAY, rsp)
  endtask
  // one-hot over a lo/hi register pair, 64 clears both
  task automatic wr64(input logic [11:0] a, input int i);
    wr(a, (i < 32) ? (32'h1 << i) : 32'h0);
    wr(a + 12'h4, (i >= 32 && i < 64) ? (32'h1 << (i - 32)) : 32'h0);
  endtask
  // settle, then compare {fast, normal}
  task automatic chk_req(input logic [1:0] e);
    repeat (10) @(posedge sys_clk);
    `CHK("normal_irq_request", e[0], normal_irq_request)
    `CHK("fast_irq_request", e[1], fast_irq_request)
  endtask
  // ==========
  // expectations
  function automatic logic [1:0] lvl_exp(input logic lvl, input logic pol, input logic fast);
    return {(lvl ^ pol) & fast, (lvl ^ pol) & !fast};
  endfunction
  // steps: low, high, low, low after clear
  function automatic logic ext_exp(input logic [2:0] m, input int st);
    case (st)
      1: return m == `VIC_MODE_HIGH || m == `VIC_MODE_RISE || m == `VIC_MODE_BOTH;
      2: return m != `VIC_MODE_HIGH;
      default: return m == `VIC_MODE_LOW;
    endcase
  endfunction
  // ==========
  // main sequence
  initial
  begin
    void'($urandom(62771));
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge sys_clk);
    `CHK("outputs after reset", 3'h0, {normal_irq_request, fast_irq_request, irq})
    foreach (rst_addr[i])
    begin
      rd(rst_addr[i]);
      `CHK("reset value", `VIC_ZERO_RST, rd_q)
    end
    bus(1'b0, 12'h048, 32'h0);
    `CHK("unmapped read", {`VIC_RESP_SLVERR, 32'h0}, {rsp, rd_q})
    bus(1'b1, 12'h048, 32'hffffffff);
    `CHK("unmapped write", `VIC_RESP_SLVERR, rsp)
    // on-chip source through every level, polarity and route
    s = $urandom % 44;
    wr64(`VIC_EN_LO, s);
    for (int i = 0; i < 8; i++)
    begin
      PM.set_src(s, i[0]);
      wr64(`VIC_POL_LO, i[1] ? s : 64);
      wr64(`VIC_ROUTE_LO, i[2] ? s : 64);
      chk_req(lvl_exp(i[0], i[1], i[2]));
    end
    wr64(`VIC_POL_LO, 64);
    wr64(`VIC_ROUTE_LO, 64);
    // normal slot vector and mask edge at its priority
    k = $urandom % 32;
    wr(12'h100 + 12'(k * 4), 32'(s) | 32'h40);
    chk_req(2'b01);
    rd(`VIC_VECT);
    `CHK("normal vector", {5'(k), 1'b1, 6'(s)}, {rd_q[12:8], rd_q[6:0]})
    wr(`VIC_PMASK, 32'h40 | 32'(k + 1));
    chk_req(2'b00);
    wr(`VIC_PMASK, 32'h40 | 32'(k));
    chk_req(2'b01);
    // fast high slot and fast mask
    wr64(`VIC_ROUTE_LO, s);
    wr(`VIC_FSLOT, (32'(s) << 8) | 32'h4000);
    rd(`VIC_VECT);
    `CHK("fast vector", {1'b1, 6'(s)}, rd_q[22:16])
    wr(`VIC_PMASK, 32'h600);
    chk_req(2'b00);
    wr(`VIC_PMASK, 32'h500);
    chk_req(2'b10);
    PM.set_src(s, 1'b0);
    wr64(`VIC_ROUTE_LO, 64);
    wr(`VIC_PMASK, 32'h0);
    // dedicated pin 0 through all five detection modes
    wr64(`VIC_EN_LO, 44);
    for (int m = 0; m < 5; m++)
    begin
      wr(`VIC_EMODE_LO, 32'(m));
      for (int st = 0; st < 4; st++)
      begin
        PM.set_src(44, st == 1);
        repeat (10) @(posedge sys_clk);
        if (st == 0 || st == 3)
          wr(`VIC_EDGE, 32'hfffff);
        chk_req({1'b0, ext_exp(3'(m), st)});
      end
    end
    // expanded pin as output, input, then interrupt
    j = $urandom % 16;
    dv = 16'($urandom);
    wr64(`VIC_EN_LO, 48 + j);
    wr(`VIC_IODATA, 32'(dv));
    wr(`VIC_IOCFG, 32'h1 << (2 * j));
    PM.set_src(48 + j, 1'b1);
    chk_req(2'b00);
    `CHK("pin enables", 16'h1 << j, io_oe)
    `CHK("pin outputs", dv, io_out)
    wr(`VIC_IOCFG, 32'h0);
    chk_req(2'b00);
    wr(`VIC_IOCFG, 32'h2 << (2 * j));
    chk_req(2'b01);
    `CHK("pin enables off", 16'h0, io_oe)
    // interrupt status, mask and clear
    PM.set_src(48 + j, 1'b0);
    chk_req(2'b00);
    wr(`VIC_ISTAT, 32'h7);
    wr(`VIC_IMASK, 32'h1);
    PM.set_src(48 + j, 1'b1);
    chk_req(2'b01);
    `CHK("irq raised", 1'b1, irq)
    rd(`VIC_ISTAT);
    `CHK("status set", 1'b1, rd_q[0])
    wr(`VIC_IMASK, 32'h0);
    chk_req(2'b01);
    `CHK("irq masked", 1'b0, irq)
    wr(`VIC_ISTAT, 32'h1);
    rd(`VIC_ISTAT);
    `CHK("status cleared", 1'b0, rd_q[0])
    conclude();
  end
endmodule
`default_nettype wire

// [dv/vic_src_model.sv]
// model of the sources feeding the controller
`timescale 1ns/100ps
`default_nettype none
module vic_src_model #(
  parameter N_INT = 44,
  parameter N_PIN = 4,
  parameter N_IO = 16
) (
  input wire logic sys_clk,
  output logic [N_INT-1:0] periph_irq,
  output logic [N_PIN-1:0] ext_int_pins,
  output logic [N_IO-1:0] io_drive
);
  // ==========
  // one level per source number
  logic [N_INT+N_PIN+N_IO-1:0] src_q = '0;
  assign periph_irq = src_q[N_INT-1:0]; // level sources on the same clock
  assign ext_int_pins = src_q[N_INT+N_PIN-1:N_INT]; // four dedicated pins
  assign io_drive = src_q[N_INT+N_PIN+N_IO-1:N_INT+N_PIN]; // far drive of expanded pins
  // move one source just after a rising edge
  task automatic set_src(input int idx, input logic lvl);
    @(posedge sys_clk);
    src_q[idx] <= lvl;
  endtask
endmodule
`default_nettype wire

// [dv/vic_top_properties.sv]
// checker of bus handshakes, request causes and pin outputs
`timescale 1ns/100ps
`default_nettype none
`include "vic_defines.vh"
module vic_top_checker #(
  parameter N_INT = 44,
  parameter N_PIN = 4,
  parameter N_IO = 16
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [N_INT-1:0] periph_irq,
  input wire logic [N_PIN-1:0] ext_int_pins,
  input wire logic [N_IO-1:0] expanded_io_pins_in,
  input wire logic [N_IO-1:0] expanded_io_pins_out,
  input wire logic [N_IO-1:0] expanded_io_pins_oe,
  input wire logic normal_irq_request,
  input wire logic fast_irq_request,
  input wire logic irq,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ==========
  // helper logic
  logic [3:0] quiet_q; // cycles since a source or a bus write last moved
  wire logic unmapped = (s_axi_araddr >= 12'h048 && s_axi_araddr < 12'h100)
    || s_axi_araddr >= 12'h180; // holes of the register map
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // restart on any input motion, saturate at the top
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      quiet_q <= 4'h0;
    else if ($changed({periph_irq, ext_int_pins, expanded_io_pins_in})
      || (s_axi_awvalid && s_axi_awready) || (s_axi_wvalid && s_axi_wready))
      quiet_q <= 4'h0;
    else if (quiet_q != 4'hf)
      quiet_q <= quiet_q + 4'h1;
  end
  // ==========
  // assertions
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response not held");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable({s_axi_rdata, s_axi_rresp})) else $error("read data not held");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid)
    else $error("write answer out of step");
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && unmapped
    |=> s_axi_rresp == `VIC_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_pin_by_write: assert property ($changed({expanded_io_pins_out, expanded_io_pins_oe})
    |-> s_axi_bvalid || $past(s_axi_bvalid)) else $error("pin output moved without a write");
  a_request_cause: assert property ($changed({normal_irq_request, fast_irq_request})
    |-> quiet_q < 4'hc) else $error("request moved without a cause");
  a_irq_cause: assert property ($rose(irq) |-> quiet_q < 4'he)
    else $error("irq rose without a cause");
  // main scenarios reached
  c_fast_raised: cover property ($rose(fast_irq_request));
  c_normal_raised: cover property ($rose(normal_irq_request));
  c_irq_raised: cover property ($rose(irq));
  c_unmapped: cover property (s_axi_arvalid && s_axi_arready && unmapped);
endmodule
bind vic_top vic_top_checker #(.N_INT(N_INT), .N_PIN(N_PIN), .N_IO(N_IO)) u_vic_chk (.*);
`default_nettype wire

// [logic/vic_ext_detect.v]
// external interrupt input conditioning: synchroniser, level and edge detection
`timescale 1ns/100ps
`default_nettype none
`include "vic_defines.vh"
module vic_ext_detect #(
  parameter W = 20
) (
  input wire sys_clk,
  input wire rst_n,
  input wire clk_en,
  input wire [W-1:0] pin_in,
  input wire [3*W-1:0] mode,
  input wire [W-1:0] edge_clr,
  output wire [W-1:0] active,
  output wire [W-1:0] level,
  output wire [W-1:0] edge_hit,
  output wire [W-1:0] edge_latch
);
  genvar g;

  // ===========================================================
  // one conditioning lane per pin
  generate
    for (g = 0; g < W; g = g + 1)
    begin : lane
      reg s1_q, s2_q, s3_q; // three-stage synchroniser
      reg lvl_q; // settled pin level
      reg edge_q; // sticky edge catch
      wire [2:0] m = mode[3*g+2:3*g];
      wire agree = (s2_q == s3_q);
      wire nxt = agree ? s3_q : lvl_q;
      wire rise = nxt & ~lvl_q;
      wire fall = ~nxt & lvl_q;
      // edge of interest for the chosen mode
      wire hit = ((m == `VIC_MODE_RISE) & rise) | ((m == `VIC_MODE_FALL) & fall) |
                 ((m == `VIC_MODE_BOTH) & (rise | fall));
      // level modes follow the pin, edge modes hold until cleared
      assign active[g] = (m == `VIC_MODE_HIGH) ? lvl_q :
                         (m == `VIC_MODE_LOW) ? ~lvl_q :
                         (m == `VIC_MODE_RISE || m == `VIC_MODE_FALL ||
                          m == `VIC_MODE_BOTH) ? edge_q : 1'b0;
      assign level[g] = lvl_q;
      assign edge_hit[g] = hit;
      assign edge_latch[g] = edge_q;

      // synchronise, settle, catch edges; a new edge beats a clear
      always @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
          lvl_q <= 1'b0;
          edge_q <= 1'b0;
        end
        else if (clk_en)
        begin
          s1_q <= pin_in[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (agree)
            lvl_q <= s3_q;
          edge_q <= hit | (edge_q & ~edge_clr[g]);
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// [logic/vic_prio_enc.v]
// priority encoder: index of the highest set request bit
`timescale 1ns/100ps
`default_nettype none
module vic_prio_enc #(
  parameter N = 32,
  parameter IW = 5
) (
  input wire [N-1:0] req,
  output reg found,
  output reg [IW-1:0] idx
);
  integer i;

  // ===========================================================
  // scan upward so the highest index wins
  always @*
  begin
    found = 1'b0;
    idx = {IW{1'b0}};
    for (i = 0; i < N; i = i + 1)
    begin
      if (req[i])
      begin
        found = 1'b1;
        idx = i[IW-1:0];
      end
    end
  end
endmodule
`default_nettype wire

// [logic/vic_top.v]
// vectored interrupt controller with AXI4-Lite register access
`timescale 1ns/100ps
`default_nettype none
`include "vic_defines.vh"
module vic_top #(
  parameter N_INT = 44,
  parameter N_PIN = 4,
  parameter N_IO = 16
) (
  input wire sys_clk,
  input wire rst_n,
  input wire clk_en,
  input wire [N_INT-1:0] periph_irq,
  input wire [N_PIN-1:0] ext_int_pins,
  input wire [N_IO-1:0] expanded_io_pins_in,
  output reg [N_IO-1:0] expanded_io_pins_out,
  output reg [N_IO-1:0] expanded_io_pins_oe,
  output reg normal_irq_request,
  output reg fast_irq_request,
  output reg irq,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  localparam NX = N_PIN + N_IO; // external lanes
  localparam NS = N_INT + NX; // all sources

  // ===========================================================
  // reset release
  reg rst_s1_q, rst_s2_q;
  wire rst_ni = rst_s2_q; // released reset for the rest

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else if (clk_en)
    begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  // ===========================================================
  // byte-lane merge for partial writes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1)
        if (strb[b])
          merge[8*b +: 8] = nw[8*b +: 8];
    end
  endfunction

  // ===========================================================
  // configuration state
  reg [63:0] en_q; // source enables
  reg [63:0] route_q; // 1 sends source to fast request
  reg [N_INT-1:0] pol_q; // 1 makes on-chip input active low
  reg [3*NX-1:0] emode_q; // external detection modes
  reg [31:0] iocfg_q; // two bits per expanded pin
  reg [N_IO-1:0] iodata_q; // expanded pin output values
  reg [31:0] pmask_q; // priority mask fields
  reg [31:0] fslot_q; // fast level slots
  reg [5:0] slot_src_q [0:31]; // normal slot source numbers
  reg [31:0] slot_v_q; // normal slot valid bits
  reg [2:0] istat_q; // sticky event bits
  reg [2:0] imask_q; // event enables
  reg [31:0] vect_q; // registered vector report

  // ===========================================================
  // bus holding state
  reg aw_full_q, w_full_q;
  reg [11:0] wa_q;
  reg [31:0] wd_q;
  reg [3:0] ws_q;
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire wr_go = aw_full_q & w_full_q & ~s_axi_bvalid; // both halves held
  wire wr_slot = (wa_q[11:7] == `VIC_SLOT_PAGE); // slot page hit
  wire [31:0] wr_bits = merge(32'h0000_0000, wd_q, ws_q); // one-bits written

  // ===========================================================
  // external detection
  wire [NX-1:0] x_active, x_level, x_hit, x_latch;
  wire [NX-1:0] x_clr = (wr_go && wa_q == `VIC_EDGE) ? wr_bits[NX-1:0] : {NX{1'b0}};

  vic_ext_detect #(.W(NX)) u_det (
    .sys_clk(sys_clk),
    .rst_n(rst_ni),
    .clk_en(clk_en),
    .pin_in({expanded_io_pins_in, ext_int_pins}),
    .mode(emode_q),
    .edge_clr(x_clr),
    .active(x_active),
    .level(x_level),
    .edge_hit(x_hit),
    .edge_latch(x_latch)
  );

  // ===========================================================
  // source assembly
  wire [N_IO-1:0] io_irq_sel; // expanded pins set up as interrupt
  genvar g;
  generate
    for (g = 0; g < N_IO; g = g + 1)
    begin : iosel
      assign io_irq_sel[g] = (iocfg_q[2*g+1:2*g] == `VIC_IO_IRQ);
    end
  endgenerate

  wire [NS-1:0] raw = {x_active[NX-1:N_PIN] & io_irq_sel, x_active[N_PIN-1:0],
                       periph_irq ^ pol_q};
  wire [NS-1:0] qual = raw & en_q[NS-1:0];

  // ===========================================================
  // per-source priority and mask suppression
  reg [NS-1:0] nsup, fsup;
  reg [5:0] np;
  reg [1:0] fp;
  integer s, k;

  always @*
  begin
    nsup = {NS{1'b0}};
    fsup = {NS{1'b0}};
    np = 6'h00;
    fp = 2'h0;
    for (s = 0; s < NS; s = s + 1)
    begin
      np = 6'h00;
      for (k = 0; k < 32; k = k + 1)
        if (slot_v_q[k] && slot_src_q[k] == s[5:0])
          np = k[5:0] + 6'h01;
      if (fslot_q[`VIC_FSLOT_HI_VALID] && fslot_q[13:8] == s[5:0])
        fp = 2'h2;
      else if (fslot_q[`VIC_SLOT_VALID] && fslot_q[5:0] == s[5:0])
        fp = 2'h1;
      else
        fp = 2'h0;
      nsup[s] = pmask_q[`VIC_PM_NEN] && (np <= pmask_q[5:0]);
      fsup[s] = pmask_q[`VIC_PM_FEN] && (fp <= pmask_q[9:8]);
    end
  end

  wire [NS-1:0] ncand = qual & ~route_q[NS-1:0] & ~nsup;
  wire [NS-1:0] fcand = qual & route_q[NS-1:0] & ~fsup;
  wire nreq_d = |ncand;
  wire freq_d = |fcand;

  // ===========================================================
  // vectoring: highest normal slot and fast level with a candidate
  reg [31:0] slot_hit;
  integer j;

  always @*
  begin
    slot_hit = 32'h0000_0000;
    for (j = 0; j < 32; j = j + 1)
      slot_hit[j] = slot_v_q[j] & ncand[slot_src_q[j]];
  end

  wire n_found, f_found;
  wire [4:0] n_idx;
  wire f_idx;
  wire [1:0] f_hit = {fslot_q[`VIC_FSLOT_HI_VALID] & fcand[fslot_q[13:8]],
                      fslot_q[`VIC_SLOT_VALID] & fcand[fslot_q[5:0]]};

  vic_prio_enc #(.N(32), .IW(5)) u_nenc (
    .req(slot_hit),
    .found(n_found),
    .idx(n_idx)
  );

  vic_prio_enc #(.N(2), .IW(1)) u_fenc (
    .req(f_hit),
    .found(f_found),
    .idx(f_idx)
  );

  wire [5:0] f_src = f_idx ? fslot_q[13:8] : fslot_q[5:0];
  wire [31:0] vect_d = {9'h000, f_found, f_src, 3'h0, n_idx, 1'b0, n_found,
                        slot_src_q[n_idx]};
  wire [2:0] ev = {|x_hit, freq_d & ~fast_irq_request, nreq_d & ~normal_irq_request};
  wire [N_IO-1:0] io_oe_sel; // expanded pins set up as output
  generate
    for (g = 0; g < N_IO; g = g + 1)
    begin : ioout
      assign io_oe_sel[g] = (iocfg_q[2*g+1:2*g] == `VIC_IO_OUT);
    end
  endgenerate

  // ===========================================================
  // request outputs, vector, events and pin drive
  always @(posedge sys_clk or negedge rst_ni)
  begin
    if (!rst_ni)
    begin
      normal_irq_request <= 1'b0;
      fast_irq_request <= 1'b0;
      vect_q <= `VIC_ZERO_RST;
      istat_q <= 3'h0;
      irq <= 1'b0;
      expanded_io_pins_out <= {N_IO{1'b0}};
      expanded_io_pins_oe <= {N_IO{1'b0}};
    end
    else if (clk_en)
    begin
      normal_irq_request <= nreq_d;
      fast_irq_request <= freq_d;
      vect_q <= vect_d;
      // set wins over write-one-to-clear
      istat_q <= ev | (istat_q & ~((wr_go && wa_q == `VIC_ISTAT) ? wr_bits[2:0] : 3'h0));
      irq <= |((ev | istat_q) & imask_q);
      expanded_io_pins_out <= iodata_q;
      expanded_io_pins_oe <= ~io_irq_sel & io_oe_sel;
    end
  end

  // ===========================================================
  // write channel and register updates
  // merged words cut to the width of narrow registers
  wire [31:0] pol_hi_m = merge({20'h00000, pol_q[N_INT-1:32]}, wd_q, ws_q);
  wire [N_INT-33:0] wr_pol_hi = pol_hi_m[N_INT-33:0];
  wire [31:0] m_eml = merge({2'h0, emode_q[29:0]}, wd_q, ws_q);
  wire [31:0] m_emh = merge({2'h0, emode_q[59:30]}, wd_q, ws_q);
  wire [31:0] m_iod = merge({16'h0000, iodata_q}, wd_q, ws_q);
  wire [31:0] m_imk = merge({29'h0, imask_q}, wd_q, ws_q);
  integer r;

  always @(posedge sys_clk or negedge rst_ni)
  begin
    if (!rst_ni)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      wa_q <= 12'h000;
      wd_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `VIC_RESP_OKAY;
      en_q <= 64'h0;
      route_q <= 64'h0;
      pol_q <= {N_INT{1'b0}};
      emode_q <= {3*NX{1'b0}};
      iocfg_q <= `VIC_ZERO_RST;
      iodata_q <= {N_IO{1'b0}};
      pmask_q <= `VIC_ZERO_RST;
      fslot_q <= `VIC_ZERO_RST;
      slot_v_q <= `VIC_ZERO_RST;
      imask_q <= 3'h0;
      for (r = 0; r < 32; r = r + 1)
        slot_src_q[r] <= 6'h00;
    end
    else if (clk_en)
    begin
      // hold each half until both are present
      if (aw_take)
      begin
        aw_full_q <= 1'b1;
        wa_q <= {s_axi_awaddr[11:2], 2'h0};
      end
      if (w_take)
      begin
        w_full_q <= 1'b1;
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      s_axi_awready <= ~(aw_take | (aw_full_q & ~wr_go));
      s_axi_wready <= ~(w_take | (w_full_q & ~wr_go));
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_go)
      begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `VIC_RESP_OKAY;
        if (wr_slot)
        begin
          // normal priority slot
          if (ws_q[0])
          begin
            slot_src_q[wa_q[6:2]] <= wd_q[5:0];
            slot_v_q[wa_q[6:2]] <= wd_q[`VIC_SLOT_VALID];
          end
        end
        else
        begin
          case (wa_q)
            `VIC_EN_LO: en_q[31:0] <= merge(en_q[31:0], wd_q, ws_q);
            `VIC_EN_HI: en_q[63:32] <= merge(en_q[63:32], wd_q, ws_q);
            `VIC_ROUTE_LO: route_q[31:0] <= merge(route_q[31:0], wd_q, ws_q);
            `VIC_ROUTE_HI: route_q[63:32] <= merge(route_q[63:32], wd_q, ws_q);
            `VIC_POL_LO: pol_q[31:0] <= merge(pol_q[31:0], wd_q, ws_q);
            `VIC_POL_HI: pol_q[N_INT-1:32] <= wr_pol_hi;
            `VIC_EMODE_LO: emode_q[29:0] <= m_eml[29:0];
            `VIC_EMODE_HI: emode_q[59:30] <= m_emh[29:0];
            `VIC_IOCFG: iocfg_q <= merge(iocfg_q, wd_q, ws_q);
            `VIC_IODATA: iodata_q <= m_iod[N_IO-1:0];
            `VIC_PMASK: pmask_q <= merge(pmask_q, wd_q, ws_q) & 32'h0000_077f;
            `VIC_FSLOT: fslot_q <= merge(fslot_q, wd_q, ws_q) & 32'h0000_7f7f;
            `VIC_IMASK: imask_q <= m_imk[2:0];
            `VIC_EDGE, `VIC_ISTAT, `VIC_PEND_LO, `VIC_PEND_HI, `VIC_VECT: ;
            default: s_axi_bresp <= `VIC_RESP_SLVERR; // unmapped
          endcase
        end
      end
    end
  end

  // ===========================================================
  // read decode
  reg [31:0] rd_d;
  reg rd_err;
  wire [63:0] pend_w = {{(64-NS){1'b0}}, raw};

  always @*
  begin
    rd_d = 32'h0000_0000;
    rd_err = 1'b0;
    if (s_axi_araddr[11:7] == `VIC_SLOT_PAGE)
      rd_d = {25'h0, slot_v_q[s_axi_araddr[6:2]], slot_src_q[s_axi_araddr[6:2]]};
    else
    begin
      case ({s_axi_araddr[11:2], 2'h0})
        `VIC_PEND_LO: rd_d = pend_w[31:0];
        `VIC_PEND_HI: rd_d = pend_w[63:32];
        `VIC_EN_LO: rd_d = en_q[31:0];
        `VIC_EN_HI: rd_d = en_q[63:32];
        `VIC_ROUTE_LO: rd_d = route_q[31:0];
        `VIC_ROUTE_HI: rd_d = route_q[63:32];
        `VIC_POL_LO: rd_d = pol_q[31:0];
        `VIC_POL_HI: rd_d = {{(64-N_INT){1'b0}}, pol_q[N_INT-1:32]};
        `VIC_EMODE_LO: rd_d = {2'h0, emode_q[29:0]};
        `VIC_EMODE_HI: rd_d = {2'h0, emode_q[59:30]};
        `VIC_EDGE: rd_d = {{(32-NX){1'b0}}, x_latch};
        `VIC_IOCFG: rd_d = iocfg_q;
        `VIC_IODATA: rd_d = {16'h0000, x_level[NX-1:N_PIN]};
        `VIC_PMASK: rd_d = pmask_q;
        `VIC_FSLOT: rd_d = fslot_q;
        `VIC_VECT: rd_d = vect_q;
        `VIC_ISTAT: rd_d = {29'h0, istat_q};
        `VIC_IMASK: rd_d = {29'h0, imask_q};
        default: rd_err = 1'b1;
      endcase
    end
  end

  // ===========================================================
  // read channel: answer one cycle after the address is taken
  always @(posedge sys_clk or negedge rst_ni)
  begin
    if (!rst_ni)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `VIC_RESP_OKAY;
    end
    else if (clk_en)
    begin
      s_axi_arready <= ~(ar_take | (s_axi_rvalid & ~s_axi_rready));
      if (ar_take)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_d;
        s_axi_rresp <= rd_err ? `VIC_RESP_SLVERR : `VIC_RESP_OKAY;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [shared/vic_defines.vh]
// register map, field positions, reset values and codes of the interrupt controller
`ifndef VIC_DEFINES_VH
`define VIC_DEFINES_VH
// register byte offsets
`define VIC_PEND_LO 12'h000
`define VIC_PEND_HI 12'h004
`define VIC_EN_LO 12'h008
`define VIC_EN_HI 12'h00c
`define VIC_ROUTE_LO 12'h010
`define VIC_ROUTE_HI 12'h014
`define VIC_POL_LO 12'h018
`define VIC_POL_HI 12'h01c
`define VIC_EMODE_LO 12'h020
`define VIC_EMODE_HI 12'h024
`define VIC_EDGE 12'h028
`define VIC_IOCFG 12'h02c
`define VIC_IODATA 12'h030
`define VIC_PMASK 12'h034
`define VIC_FSLOT 12'h038
`define VIC_VECT 12'h03c
`define VIC_ISTAT 12'h040
`define VIC_IMASK 12'h044
// normal priority slot k sits at base + 4*k
`define VIC_SLOT_PAGE 5'h02
// field positions of priority mask register
`define VIC_PM_NLEV_LSB 0
`define VIC_PM_NEN 6
`define VIC_PM_FLEV_LSB 8
`define VIC_PM_FEN 10
// field positions of slot registers
`define VIC_SLOT_VALID 6
`define VIC_FSLOT_HI_LSB 8
`define VIC_FSLOT_HI_VALID 14
// external detection modes
`define VIC_MODE_HIGH 3'h0
`define VIC_MODE_LOW 3'h1
`define VIC_MODE_RISE 3'h2
`define VIC_MODE_FALL 3'h3
`define VIC_MODE_BOTH 3'h4
// expanded pin configuration
`define VIC_IO_IN 2'h0
`define VIC_IO_OUT 2'h1
`define VIC_IO_IRQ 2'h2
// reset values
`define VIC_ZERO_RST 32'h0000_0000
// bus responses
`define VIC_RESP_OKAY 2'h0
`define VIC_RESP_SLVERR 2'h2
`endif
